// ===== logic/drldc_cfg.svh
`ifndef DRLDC_CFG_SVH
`define DRLDC_CFG_SVH
`define DRLDC_OFS_CTRL 5'h00
`define DRLDC_OFS_LO 5'h04
`define DRLDC_OFS_HI 5'h08
`define DRLDC_OFS_STP 5'h0c
`define DRLDC_OFS_STN 5'h10
`define DRLDC_OFS_RATE 5'h14
`define DRLDC_OFS_OUT 5'h18
`define DRLDC_OFS_STAT 5'h1c
`define DRLDC_CTRL_W 7
`define DRLDC_RST_CTRL 7'h00
`define DRLDC_RST_LO 32'h0000_0000
`define DRLDC_RST_HI 32'hffff_ffff
`define DRLDC_RST_STEP 32'h0000_0000
`define DRLDC_RST_RATE 16'h0001
`define DRLDC_TIMER_ONE 16'h0001
`define DRLDC_PULSE_CYC 2'h2
`endif

// ===== logic/drldc_pkg.sv
package drldc_pkg;
  typedef enum logic [1:0] {
    st_off = 2'h0,
    st_up = 2'h1,
    st_down = 2'h3,
    st_wait = 2'h2
  } drldc_st_t;

  // Bit 0 is enable, bit 6 is reload on commit.
  typedef struct packed {
    logic reload_upd;
    logic flag_en;
    logic nd_lo;
    logic nd_hi;
    logic autoclr;
    logic clr;
    logic enable;
  } drldc_ctrl_t;

  typedef struct packed {
    drldc_ctrl_t ctrl;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] stp;
    logic [31:0] stn;
    logic [15:0] rate_n;
    logic [15:0] rate_p;
  } drldc_cfg_t;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } drldc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } drldc_avs_rsp_t;

  typedef struct packed {
    logic sweep_direction_pin;
    logic sweep_hold_pin;
    logic sweep_update_pin;
  } drldc_pins_t;

  typedef struct packed {
    logic dir_m;
    logic dir_s;
    logic dir_q;
    logic hold_m;
    logic hold_s;
    logic upd_m;
    logic upd_s;
    logic upd_q;
    drldc_cfg_t stg;
    drldc_cfg_t act;
    drldc_st_t st;
    logic [31:0] acc;
    logic [15:0] timer;
    logic aclr;
    logic [1:0] pulse;
    logic flag;
    logic wait_q;
    logic [31:0] rdata;
  } drldc_state_t;
endpackage

// ===== logic/drldc_top.sv
`timescale 1ns/1ps
`include "drldc_cfg.svh"
// Contract
// - While enabled, the output never leaves the lower and upper bounds.
// - Clearing the accumulator puts the output at the lower bound.
// - Enable acts at commit; direction high ramps up (single no-dwell modes wait instead), low loads lower bound.
// - Normal mode rests at upper bound until clear, direction low, higher bound.
// - Normal mode rests at lower bound until direction high or lower bound.
// - Hold high freezes the accumulator unless a clear is active; release resumes the slope.
// - Committed clear bit holds output at lower bound until committed cleared.
// - Committed auto-clear holds accumulator cleared for exactly one cycle.
// - Normal behaviour only with both no-dwell bits cleared.
// - No-dwell-high jumps from upper bound straight to lower bound.
// - No-dwell-low jumps from lower bound straight to upper bound.
// - In single no-dwell modes only direction pin edges matter, not its level.
// - No-dwell-high starts on rising edge, ignores pin until upper bound.
// - No-dwell-low starts on falling edge, ignores pin until lower bound.
// - Both no-dwell bits make the output oscillate between the bounds.
// - In oscillation, direction edges switch slope: rising up, falling down.
// - With flag enabled outside oscillation, flag is high exactly while output sits at a bound.
// - In oscillation, flag pulses two cycles at each bound reached.
// - No-dwell-high ignores a falling direction edge during the up ramp.
// - Normal mode: direction low ramps down, direction high ramps up.
// - 32-bit accumulator stepped by a timer with separate 16-bit intervals.
// - Step sizes are unsigned; the down step is subtracted.
// - Timer reloads on direction change, enable commit, optional every commit.
module drldc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire drldc_pkg::drldc_avs_req_t avs_req,
  output drldc_pkg::drldc_avs_rsp_t avs_rsp,
  // Control pins
  input wire drldc_pkg::drldc_pins_t pins,
  // Sweep outputs
  output logic [31:0] sweep_out,
  output logic sweep_limit_flag_pin
);
  import drldc_pkg::*;

  localparam drldc_cfg_t RST_CFG = '{
    ctrl: drldc_ctrl_t'(`DRLDC_RST_CTRL),
    lo: `DRLDC_RST_LO,
    hi: `DRLDC_RST_HI,
    stp: `DRLDC_RST_STEP,
    stn: `DRLDC_RST_STEP,
    rate_n: `DRLDC_RST_RATE,
    rate_p: `DRLDC_RST_RATE
  };

  drldc_state_t q;
  drldc_state_t n;
  logic en, both, nd_h, nd_l, nd_any, clr_now, run, tick;
  logic dir_rise, dir_fall, commit, req, hit_hi, hit_lo;
  logic [4:0] word;
  logic [31:0] base, wmerge, rd_mux;
  logic [32:0] sum, diff;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign en = q.act.ctrl.enable;
  assign both = q.act.ctrl.nd_hi & q.act.ctrl.nd_lo;
  assign nd_h = q.act.ctrl.nd_hi & ~q.act.ctrl.nd_lo;
  assign nd_l = q.act.ctrl.nd_lo & ~q.act.ctrl.nd_hi;
  assign nd_any = q.act.ctrl.nd_hi | q.act.ctrl.nd_lo;
  assign clr_now = q.act.ctrl.clr | q.aclr;
  assign dir_rise = q.dir_s & ~q.dir_q;
  assign dir_fall = ~q.dir_s & q.dir_q;
  assign commit = q.upd_s & ~q.upd_q;
  // Feedback limit keeps the output inside the bounds even if they move.
  assign base = (q.acc > q.act.hi) ? q.act.hi :
                (q.acc < q.act.lo) ? q.act.lo : q.acc;
  assign run = en & ~q.hold_s & ~clr_now & (q.st == st_up || q.st == st_down);
  assign tick = run & (q.timer <= `DRLDC_TIMER_ONE);
  assign sum = {1'b0, base} + {1'b0, q.act.stp};
  assign diff = {1'b0, base} - {1'b0, q.act.stn};
  // A bound closer than one step is treated as reached; with hi not above lo
  // the sweep simply sits at a bound.
  assign hit_hi = tick & (q.st == st_up) & (sum >= {1'b0, q.act.hi});
  assign hit_lo = tick & (q.st == st_down) & (diff[32] | (diff[31:0] <= q.act.lo));

  assign req = avs_req.read | avs_req.write;
  assign word = {avs_req.address[4:2], 2'b00};
  assign rd_mux = (word == `DRLDC_OFS_CTRL) ? {25'h000_0000, q.stg.ctrl} :
                  (word == `DRLDC_OFS_LO) ? q.stg.lo :
                  (word == `DRLDC_OFS_HI) ? q.stg.hi :
                  (word == `DRLDC_OFS_STP) ? q.stg.stp :
                  (word == `DRLDC_OFS_STN) ? q.stg.stn :
                  (word == `DRLDC_OFS_RATE) ? {q.stg.rate_n, q.stg.rate_p} :
                  (word == `DRLDC_OFS_OUT) ? q.acc :
                  {q.timer, 10'h000, q.aclr, q.hold_s, q.dir_s, q.flag, q.st};
  assign wmerge = be_merge(rd_mux, avs_req.writedata, avs_req.byteenable);

  always_comb begin
    n = q;
    n.dir_m = pins.sweep_direction_pin;
    n.dir_s = q.dir_m;
    n.dir_q = q.dir_s;
    n.hold_m = pins.sweep_hold_pin;
    n.hold_s = q.hold_m;
    n.upd_m = pins.sweep_update_pin;
    n.upd_s = q.upd_m;
    n.upd_q = q.upd_s;
    n.aclr = 1'b0;
    // Bus: the answer is always one wait cycle, so reads need no mux timing.
    n.wait_q = ~(req & q.wait_q);
    if (req & q.wait_q) begin
      n.rdata = avs_req.read ? rd_mux : 32'h0000_0000;
    end
    if (avs_req.write & ~q.wait_q) begin
      case (word)
        `DRLDC_OFS_CTRL: n.stg.ctrl = drldc_ctrl_t'(wmerge[`DRLDC_CTRL_W-1:0]);
        `DRLDC_OFS_LO: n.stg.lo = wmerge;
        `DRLDC_OFS_HI: n.stg.hi = wmerge;
        `DRLDC_OFS_STP: n.stg.stp = wmerge;
        `DRLDC_OFS_STN: n.stg.stn = wmerge;
        `DRLDC_OFS_RATE: {n.stg.rate_n, n.stg.rate_p} = wmerge;
        default: n.stg = q.stg;
      endcase
    end
    // Sweep direction.
    if (!en) begin
      n.st = st_off;
    end else if (!nd_any) begin
      n.st = q.dir_s ? st_up : st_down;
    end else if (both) begin
      if (dir_rise) begin
        n.st = st_up;
      end else if (dir_fall) begin
        n.st = st_down;
      end else if (q.st == st_wait || q.st == st_off) begin
        n.st = q.dir_s ? st_up : st_down;
      end
    end else if (nd_h) begin
      if (q.st != st_up) begin
        n.st = dir_rise ? st_up : st_wait;
      end
    end else if (nd_l) begin
      if (q.st != st_down) begin
        n.st = dir_fall ? st_down : st_wait;
      end
    end
    // Accumulator.
    if (en) begin
      n.acc = base;
      if (clr_now) begin
        n.acc = q.act.lo;
      end else if (hit_hi) begin
        n.acc = q.act.hi;
        if (nd_h) begin
          n.acc = q.act.lo;
          n.st = st_wait;
        end else if (both) begin
          n.st = st_down;
        end
      end else if (hit_lo) begin
        n.acc = q.act.lo;
        if (nd_l) begin
          n.acc = q.act.hi;
          n.st = st_wait;
        end else if (both) begin
          n.st = st_up;
        end
      end else if (tick) begin
        n.acc = (q.st == st_up) ? sum[31:0] : diff[31:0];
      end
    end
    // Commit strobe.
    if (commit) begin
      n.act = q.stg;
      n.aclr = q.stg.ctrl.autoclr;
      if (q.stg.ctrl.enable & ~en) begin
        n.st = (q.stg.ctrl.nd_hi ^ q.stg.ctrl.nd_lo) ? st_wait :
               (q.dir_s ? st_up : st_down);
        if (!q.dir_s) begin
          n.acc = q.stg.lo;
        end
      end
    end
    // A commit may move the bounds or enable the sweep with a stale value, so the
    // output is clamped here too; otherwise it could show outside for one cycle.
    if (n.act.ctrl.enable) begin
      if (n.acc > n.act.hi) begin
        n.acc = n.act.hi;
      end else if (n.acc < n.act.lo) begin
        n.acc = n.act.lo;
      end
    end
    // Step timer.
    if (tick) begin
      n.timer = (n.st == st_down) ? n.act.rate_n : n.act.rate_p;
    end else if (run) begin
      n.timer = q.timer - `DRLDC_TIMER_ONE;
    end
    if (dir_rise | dir_fall | (commit & q.stg.ctrl.enable & ~en) |
        (commit & q.stg.ctrl.reload_upd)) begin
      n.timer = (n.st == st_down) ? n.act.rate_n : n.act.rate_p;
    end
    // Limit flag.
    if (both & (hit_hi | hit_lo)) begin
      n.pulse = `DRLDC_PULSE_CYC;
    end else if (q.pulse != 2'h0) begin
      n.pulse = q.pulse - 2'h1;
    end
    n.flag = n.act.ctrl.enable & n.act.ctrl.flag_en &
             ((n.act.ctrl.nd_hi & n.act.ctrl.nd_lo) ? (n.pulse != 2'h0) :
              (n.acc == n.act.hi || n.acc == n.act.lo));
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.stg <= RST_CFG;
      q.act <= RST_CFG;
      q.wait_q <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign avs_rsp.readdata = q.rdata;
  assign avs_rsp.waitrequest = q.wait_q;
  assign sweep_out = q.acc;
  assign sweep_limit_flag_pin = q.flag;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_bounds;
    en && $past(en) && $stable(q.act) && q.act.hi > q.act.lo
      |-> q.acc >= q.act.lo && q.acc <= q.act.hi;
  endproperty
  a_bounds: assert property (p_bounds) else $error("output outside bounds");

  property p_clr;
    en && q.act.ctrl.clr && !commit |=> q.acc == $past(q.act.lo);
  endproperty
  a_clr: assert property (p_clr) else $error("clear not at lower bound");

  property p_aclr;
    commit && q.stg.ctrl.autoclr && q.stg.ctrl.enable && en && !q.stg.ctrl.clr
      |=> q.aclr ##1 !q.aclr && q.acc == $past(q.act.lo);
  endproperty
  a_aclr: assert property (p_aclr) else $error("auto clear wrong");

  property p_enable;
    commit && q.stg.ctrl.enable && !en && !q.dir_s |=> q.acc == $past(q.stg.lo);
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not load lower");

  property p_hold;
    en && q.hold_s && !clr_now && !commit && $stable(q.act) |=> $stable(q.acc);
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not freeze");

  property p_nd_hi;
    nd_h && hit_hi && !commit |=> q.acc == $past(q.act.lo) && q.st == st_wait;
  endproperty
  a_nd_hi: assert property (p_nd_hi) else $error("no jump to lower");

  property p_nd_lo;
    nd_l && hit_lo && !commit |=> q.acc == $past(q.act.hi) && q.st == st_wait;
  endproperty
  a_nd_lo: assert property (p_nd_lo) else $error("no jump to upper");

  property p_ignore;
    en && nd_h && q.st == st_up && !hit_hi && !commit |=> q.st == st_up;
  endproperty
  a_ignore: assert property (p_ignore) else $error("up ramp interrupted");

  property p_osc;
    en && both && hit_hi && !dir_rise && !dir_fall && !commit |=> q.st == st_down;
  endproperty
  a_osc: assert property (p_osc) else $error("no turn at upper");

  property p_normal;
    en && !nd_any && q.dir_s && !commit |=> q.st == st_up;
  endproperty
  a_normal: assert property (p_normal) else $error("direction ignored");

  property p_flag;
    en && q.act.ctrl.flag_en && !both
      |-> q.flag == (q.acc == q.act.hi || q.acc == q.act.lo);
  endproperty
  a_flag: assert property (p_flag) else $error("flag level wrong");

  property p_pulse;
    en && both && (hit_hi || hit_lo) && !commit && q.act.ctrl.flag_en |=> q.flag [*2];
  endproperty
  a_pulse: assert property (p_pulse) else $error("flag pulse short");

  property p_reload;
    en && !nd_any && (dir_rise || dir_fall) && !commit
      |=> q.timer == (q.dir_q ? $past(q.act.rate_p) : $past(q.act.rate_n));
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");

  c_osc: cover property (both && hit_lo ##[1:200] both && hit_hi);
  c_nd_hi: cover property (nd_h && hit_hi);
  c_aclr: cover property (q.aclr);
  c_hold: cover property (q.hold_s && en && q.st == st_up);
endmodule // drldc_top

// ===== tb/drldc_ctl_model.sv
`timescale 1ns/1ps
module drldc_ctl_model (
  // Clock
  input wire logic core_clk,
  // Pins toward the sweep block
  output drldc_pkg::drldc_pins_t pins
);
  import drldc_pkg::*;

  initial begin
    pins = '0;
  end

  task automatic set_pins(input logic dir, input logic hold);
    @(posedge core_clk);
    pins.sweep_direction_pin <= dir;
    pins.sweep_hold_pin <= hold;
  endtask

  // The strobe rests low between commits so the synchroniser sees each edge.
  task automatic commit();
    @(posedge core_clk);
    pins.sweep_update_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    pins.sweep_update_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // drldc_ctl_model

// ===== tb/drldc_tb.sv
`timescale 1ns/1ps
`include "drldc_cfg.svh"
module testbench;
  import drldc_pkg::*;
  logic core_clk;
  logic nrst;
  drldc_avs_req_t req;
  drldc_avs_rsp_t rsp;
  drldc_pins_t pins;
  logic [31:0] sweep_out;
  logic flag;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [31:0] rnd;
  logic osc = 1'b0;
  logic osc_run = 1'b0;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h128c;
  int run = 0;

  drldc_top dut (.core_clk(core_clk), .nrst(nrst), .avs_req(req), .avs_rsp(rsp), .pins(pins),
    .sweep_out(sweep_out), .sweep_limit_flag_pin(flag));
  drldc_ctl_model ctl (.core_clk(core_clk), .pins(pins));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low; reads leave a note.
  task automatic bus(input logic [4:0] a, input logic wr, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge core_clk);
    req.address <= a;
    req.read <= ~wr;
    req.write <= wr;
    req.byteenable <= be;
    req.writedata <= d;
    if (!wr) notes.push_back({m, d});
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    bus(a, 1'b1, be, d, 32'h0000_0000);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    bus(a, 1'b0, 4'h0, e, m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    if (req.read === 1'b1 && rsp.waitrequest === 1'b0) begin
      note = notes.pop_front();
      check(rsp.readdata & note[63:32], note[31:0]);
    end
  end

  // A flag run is judged only if oscillation was active when it began.
  always @(posedge core_clk) begin
    if (flag === 1'b1) begin
      if (run == 0) osc_run = osc;
      run++;
    end else begin
      if (run != 0 && osc_run) check(run, 2);
      run = 0;
    end
  end

  initial begin
    #1ms;
    error_cnt++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    rd(`DRLDC_OFS_CTRL, 32'h0000_0000);
    rd(`DRLDC_OFS_HI, `DRLDC_RST_HI);
    rd(`DRLDC_OFS_RATE, 32'h0001_0001);
    rd(`DRLDC_OFS_OUT, 32'h0000_0000);
    rnd = $random(seed);
    wr(`DRLDC_OFS_STN, 32'h0000_0000);
    wr(`DRLDC_OFS_STN, rnd, 4'h3);
    rd(`DRLDC_OFS_STN, {16'h0000, rnd[15:0]});
    $display("test registers done");
    wr(`DRLDC_OFS_LO, 32'h0000_0010);
    wr(`DRLDC_OFS_HI, 32'h0000_0045);
    wr(`DRLDC_OFS_STP, 32'h0000_0010);
    wr(`DRLDC_OFS_STN, 32'h0000_0008);
    ctl.set_pins(1'b1, 1'b0);
    wr(`DRLDC_OFS_CTRL, 32'h0000_0021);
    settle(20);
    rd(`DRLDC_OFS_OUT, 32'h0000_0000);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0045);
    rd(`DRLDC_OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    check(flag, 1'b1);
    check(sweep_out, 32'h0000_0045);
    ctl.set_pins(1'b0, 1'b1);
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0045);
    ctl.set_pins(1'b0, 1'b0);
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0010);
    ctl.set_pins(1'b1, 1'b0);
    settle(30);
    wr(`DRLDC_OFS_HI, 32'h0000_0080);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0080);
    $display("test normal ramp done");
    wr(`DRLDC_OFS_CTRL, 32'h0000_0023);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0010);
    wr(`DRLDC_OFS_CTRL, 32'h0000_0021);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0080);
    wr(`DRLDC_OFS_CTRL, 32'h0000_0025);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0080);
    $display("test clear done");
    wr(`DRLDC_OFS_CTRL, 32'h0000_0031);
    ctl.commit();
    settle(10);
    ctl.set_pins(1'b0, 1'b0);
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0080);
    wr(`DRLDC_OFS_CTRL, 32'h0000_0021);
    ctl.commit();
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0010);
    wr(`DRLDC_OFS_CTRL, 32'h0000_0029);
    ctl.commit();
    settle(10);
    ctl.set_pins(1'b1, 1'b0);
    settle(30);
    rd(`DRLDC_OFS_OUT, 32'h0000_0010);
    rd(`DRLDC_OFS_STAT, 32'h0000_0002, 32'h0000_0003);
    $display("test no-dwell done");
    wr(`DRLDC_OFS_CTRL, 32'h0000_0039);
    ctl.commit();
    settle(20);
    osc <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      settle(5 + ($unsigned($random(seed)) % 20));
      ctl.set_pins(i[0], 1'b0);
      rd(`DRLDC_OFS_STAT, 32'h0000_0001, 32'h0000_0001);
    end
    settle(40);
    $display("test oscillation done");
    stop_test();
  end
endmodule // testbench
